// File: logic/pio_defines.vh
// Constants for the parallel port block: widths, reset values, bit positions
// and timing counts. Assumes a 125 MHz core clock.
`ifndef PIO_DEFINES_VH
`define PIO_DEFINES_VH

// Port width and reset values
`define PIO_W 8
`define PIO_RST_LATCH 8'hff
`define PIO_ALL_ONES 8'hff

// Port one alternate input positions
`define PIO_P1_T2 0
`define PIO_P1_TIMER_TWO_TRIGGER_INPUT 1
`define PIO_P1_SS 5

// Port two PWM bits
`define PIO_P2_PWM0 6
`define PIO_P2_PWM1 7

// Port three alternate positions
`define PIO_P3_RXD 0
`define PIO_P3_TXD 1
`define PIO_P3_EXT_IRQ_ZERO 2
`define PIO_P3_EXT_IRQ_ONE 3
`define PIO_P3_T0 4
`define PIO_P3_T1 5
`define PIO_P3_WR 6
`define PIO_P3_RD 7

// Port select codes on the core bus
`define PIO_SEL_P0 2'h0
`define PIO_SEL_P1 2'h1
`define PIO_SEL_P2 2'h2
`define PIO_SEL_P3 2'h3

// Glitch filter: reject pulses up to 50 ns at 8 ns per cycle
`define PIO_GLITCH_NS 50
`define PIO_CLK_NS 8
`define PIO_FILT_CYC ((`PIO_GLITCH_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS)
`define PIO_FILT_W 3

`endif

// File: logic/pio_glitch_filt.v
// Glitch filter: output follows input only after it stays stable long enough.
// Assumes input already synchronised to sys_clk.
`include "pio_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module pio_glitch_filt (
   input wire sys_clk,
   input wire reset_n,
   input wire din,
   output reg dout
);

   // Stable-time counter
   reg [`PIO_FILT_W-1:0] cnt_reg;

   // Count while input differs; accept after the full window
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_reg <= {`PIO_FILT_W{1'b0}};
         dout <= 1'b1;
      end
      else if (din == dout)
      begin
         cnt_reg <= {`PIO_FILT_W{1'b0}};
      end
      else if (cnt_reg == `PIO_FILT_CYC)
      begin
         dout <= din;
         cnt_reg <= {`PIO_FILT_W{1'b0}};
      end
      else
      begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

endmodule // pio_glitch_filt

`default_nettype wire

// File: logic/pio_ports.v
// Four 8-bit parallel ports with latch, read-latch and read-pin paths,
// external memory takeover, alternate functions and serial pin drive.
// Assumes a core bus with one-cycle strobes, all on sys_clk.
`include "pio_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module pio_ports (
   input wire sys_clk,
   input wire reset_n,
   // Core bus side
   input wire [1:0] bus_sel,
   input wire bus_wr_latch,
   input wire bus_rd_latch,
   input wire bus_rd_pin,
   input wire bus_rmw,
   input wire [7:0] bus_wdata,
   output reg [7:0] bus_rdata,
   // External memory control
   input wire ext_mem_active,
   input wire ext_data_phase,
   input wire [7:0] ext_addr_low,
   input wire [7:0] ext_data_out,
   input wire [7:0] ext_addr_high,
   // Chip configuration
   input wire pwm_to_port_two,
   input wire pwm_to_port_three,
   input wire pwm_out0,
   input wire pwm_out1,
   // Port three alternate outputs from peripherals
   input wire uart_txd_alt,
   input wire uart_rxd_out_alt,
   input wire uart_rxd_oe_alt,
   input wire spi_miso_alt,
   input wire spi_miso_oe_alt,
   input wire ext_wr_strobe_n,
   input wire ext_rd_strobe_n,
   // Serial pin controls
   input wire spi_select_bit,
   input wire i2c_master_mode,
   input wire spi_sclk_out,
   input wire spi_sclk_oe,
   input wire spi_mosi_out,
   input wire spi_mosi_oe,
   input wire sw_serial_clock_out,
   input wire sw_serial_data_out,
   // Pin inputs
   input wire [7:0] port_zero_pin_in,
   input wire [7:0] port_one_pin_in,
   input wire [7:0] port_two_pin_in,
   input wire [7:0] port_three_pin_in,
   input wire serial_clock_pin_in,
   input wire serial_data_pin_in,
   // Pin outputs
   output reg [7:0] port_zero_out,
   output reg [7:0] port_zero_oe,
   output reg [7:0] port_two_out,
   output reg [7:0] port_two_oe,
   output reg [7:0] port_two_weak,
   output reg [7:0] port_three_out,
   output reg [7:0] port_three_oe,
   output reg [7:0] port_three_weak,
   output reg [7:0] port_one_analog_sel,
   output reg serial_clock_out,
   output reg serial_clock_oe,
   output reg serial_clock_weak,
   output reg serial_data_out,
   output reg serial_data_oe,
   output reg serial_data_weak,
   // Alternate inputs to peripherals
   output reg timer_two_count_input,
   output reg timer_two_trigger_input,
   output reg spi_slave_select_n,
   output reg uart_rxd_in,
   output reg ext_irq_zero,
   output reg ext_irq_one,
   output reg timer_zero_count_input,
   output reg timer_one_count_input,
   output reg pwm_ext_clock_in,
   output reg i2c_scl_in,
   output reg i2c_sda_in,
   output reg spi_sclk_in,
   output reg spi_mosi_in
);

   // Port latches
   reg [7:0] port_zero_latch;
   reg [7:0] port_one_latch;
   reg [7:0] port_two_latch;
   reg [7:0] port_three_latch;

   // Synchronised pin levels
   wire [7:0] p0_sync;
   wire [7:0] p1_sync;
   wire [7:0] p2_sync;
   wire [7:0] p3_sync;
   wire [1:0] ser_sync;
   wire scl_filt;
   wire sda_filt;

   // Combinational next pin drive
   reg [7:0] p0_out_next;
   reg [7:0] p0_oe_next;
   reg [7:0] p2_out_next;
   reg [7:0] p2_oe_next;
   reg [7:0] p2_weak_next;
   reg [7:0] p3_alt_val;
   reg [7:0] p3_alt_oe;
   reg [7:0] p3_out_next;
   reg [7:0] p3_oe_next;
   reg [7:0] p3_weak_next;
   reg [7:0] rdata_next;

   // Pin synchronisers
   pio_sync_bit #(.W(8)) u_sync_p0 (.sys_clk(sys_clk), .reset_n(reset_n),
      .async_in(port_zero_pin_in), .sync_out(p0_sync));
   pio_sync_bit #(.W(8)) u_sync_p1 (.sys_clk(sys_clk), .reset_n(reset_n),
      .async_in(port_one_pin_in), .sync_out(p1_sync));
   pio_sync_bit #(.W(8)) u_sync_p2 (.sys_clk(sys_clk), .reset_n(reset_n),
      .async_in(port_two_pin_in), .sync_out(p2_sync));
   pio_sync_bit #(.W(8)) u_sync_p3 (.sys_clk(sys_clk), .reset_n(reset_n),
      .async_in(port_three_pin_in), .sync_out(p3_sync));
   pio_sync_bit #(.W(2)) u_sync_ser (.sys_clk(sys_clk), .reset_n(reset_n),
      .async_in({serial_data_pin_in, serial_clock_pin_in}), .sync_out(ser_sync));

   // Glitch filters toward the I2C logic
   pio_glitch_filt u_filt_scl (.sys_clk(sys_clk), .reset_n(reset_n),
      .din(ser_sync[0]), .dout(scl_filt));
   pio_glitch_filt u_filt_sda (.sys_clk(sys_clk), .reset_n(reset_n),
      .din(ser_sync[1]), .dout(sda_filt));

   // Latch writes; RMW writes back a full byte
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         port_zero_latch <= `PIO_RST_LATCH;
         port_one_latch <= `PIO_RST_LATCH;
         port_two_latch <= `PIO_RST_LATCH;
         port_three_latch <= `PIO_RST_LATCH;
      end
      else
      begin
         // External access forces ones, winning over a write
         if (ext_mem_active)
         begin
            port_zero_latch <= `PIO_ALL_ONES;
         end
         else if (bus_wr_latch && bus_sel == `PIO_SEL_P0)
         begin
            port_zero_latch <= bus_wdata;
         end
         if (bus_wr_latch && bus_sel == `PIO_SEL_P1)
         begin
            port_one_latch <= bus_wdata;
         end
         // Port two latch untouched by external access
         if (bus_wr_latch && bus_sel == `PIO_SEL_P2)
         begin
            port_two_latch <= bus_wdata;
         end
         if (bus_wr_latch && bus_sel == `PIO_SEL_P3)
         begin
            port_three_latch <= bus_wdata;
         end
      end
   end

   // Read data: latch path for reads and RMW, pin path for pin reads, zero with no strobe
   always @*
   begin
      rdata_next = 8'h00;
      if (bus_rd_latch || bus_rmw)
      begin
         case (bus_sel)
            `PIO_SEL_P0: rdata_next = port_zero_latch;
            `PIO_SEL_P1: rdata_next = port_one_latch;
            `PIO_SEL_P2: rdata_next = port_two_latch;
            default: rdata_next = port_three_latch;
         endcase
      end
      else if (bus_rd_pin)
      begin
         case (bus_sel)
            `PIO_SEL_P0: rdata_next = p0_sync;
            `PIO_SEL_P1: rdata_next = p1_sync;
            `PIO_SEL_P2: rdata_next = p2_sync;
            default: rdata_next = p3_sync;
         endcase
      end
   end

   // Port zero and two drive
   always @*
   begin
      if (ext_mem_active)
      begin
         // Address then data, driven both ways
         p0_out_next = ext_data_phase ? ext_data_out : ext_addr_low;
         p0_oe_next = `PIO_ALL_ONES;
         p2_out_next = ext_addr_high;
         p2_oe_next = `PIO_ALL_ONES;
         p2_weak_next = 8'h00;
      end
      else
      begin
         // Open drain: only a zero is driven
         p0_out_next = 8'h00;
         p0_oe_next = ~port_zero_latch;
         // Quasi-bidirectional: one is weak pull-up
         p2_out_next = 8'h00;
         p2_oe_next = ~port_two_latch;
         p2_weak_next = port_two_latch;
      end
      if (pwm_to_port_two)
      begin
         // PWM takes bits six and seven
         p2_out_next[`PIO_P2_PWM0] = pwm_out0;
         p2_out_next[`PIO_P2_PWM1] = pwm_out1;
         p2_oe_next[`PIO_P2_PWM0] = 1'b1;
         p2_oe_next[`PIO_P2_PWM1] = 1'b1;
         p2_weak_next[`PIO_P2_PWM0] = 1'b0;
         p2_weak_next[`PIO_P2_PWM1] = 1'b0;
      end
   end

   // Port three alternate output sources
   always @*
   begin
      p3_alt_val = `PIO_ALL_ONES;
      p3_alt_oe = 8'h00;
      p3_alt_val[`PIO_P3_RXD] = uart_rxd_out_alt;
      p3_alt_oe[`PIO_P3_RXD] = uart_rxd_oe_alt;
      p3_alt_val[`PIO_P3_TXD] = uart_txd_alt;
      p3_alt_val[`PIO_P3_WR] = ext_wr_strobe_n;
      p3_alt_val[`PIO_P3_RD] = ext_rd_strobe_n;
      p3_alt_val[`PIO_P3_EXT_IRQ_ONE] = spi_miso_alt;
      p3_alt_oe[`PIO_P3_EXT_IRQ_ONE] = spi_miso_oe_alt;
   end

   // Port three quasi-bidirectional drive, gated by the latch
   genvar gi;
   generate
      for (gi = 0; gi < `PIO_W; gi = gi + 1)
      begin : g_p3
         always @*
         begin
            if (!port_three_latch[gi])
            begin
               // Latch zero holds the pin low
               p3_out_next[gi] = 1'b0;
               p3_oe_next[gi] = 1'b1;
               p3_weak_next[gi] = 1'b0;
            end
            else
            begin
               // Alternate drives low or strong, else weak high
               p3_out_next[gi] = p3_alt_val[gi];
               p3_oe_next[gi] = p3_alt_oe[gi] | ~p3_alt_val[gi];
               p3_weak_next[gi] = 1'b1;
            end
         end
      end
   endgenerate

   // Registered outputs
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         bus_rdata <= 8'h00;
         port_zero_out <= 8'h00;
         port_zero_oe <= 8'h00;
         port_two_out <= 8'h00;
         port_two_oe <= 8'h00;
         port_two_weak <= `PIO_ALL_ONES;
         port_three_out <= `PIO_ALL_ONES;
         port_three_oe <= 8'h00;
         port_three_weak <= `PIO_ALL_ONES;
         port_one_analog_sel <= `PIO_RST_LATCH;
      end
      else
      begin
         bus_rdata <= rdata_next;
         port_zero_out <= p0_out_next;
         port_zero_oe <= p0_oe_next;
         port_two_out <= p2_out_next;
         port_two_oe <= p2_oe_next;
         port_two_weak <= p2_weak_next;
         port_three_out <= p3_out_next;
         port_three_oe <= p3_oe_next;
         port_three_weak <= p3_weak_next;
         // PWM overrides bits four and three after latch gating
         if (pwm_to_port_three)
         begin
            port_three_out[`PIO_P3_T0] <= pwm_out0;
            port_three_out[`PIO_P3_EXT_IRQ_ONE] <= pwm_out1;
            port_three_oe[`PIO_P3_T0] <= 1'b1;
            port_three_oe[`PIO_P3_EXT_IRQ_ONE] <= 1'b1;
            port_three_weak[`PIO_P3_T0] <= 1'b0;
            port_three_weak[`PIO_P3_EXT_IRQ_ONE] <= 1'b0;
         end
         // Port one: no drive, latch picks analogue or digital
         port_one_analog_sel <= port_one_latch;
      end
   end

   // Serial pins: weak open drain for I2C, push-pull for SPI
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         serial_clock_out <= 1'b1;
         serial_clock_oe <= 1'b0;
         serial_clock_weak <= 1'b1;
         serial_data_out <= 1'b1;
         serial_data_oe <= 1'b0;
         serial_data_weak <= 1'b1;
      end
      else if (spi_select_bit)
      begin
         // SPI hardware drives both levels
         serial_clock_out <= spi_sclk_out;
         serial_clock_oe <= spi_sclk_oe;
         serial_clock_weak <= 1'b0;
         serial_data_out <= spi_mosi_out;
         serial_data_oe <= spi_mosi_oe;
         serial_data_weak <= 1'b0;
      end
      else
      begin
         // Strong high off; only pull low, weak pull-up stays
         serial_clock_out <= 1'b0;
         serial_clock_oe <= i2c_master_mode & ~sw_serial_clock_out;
         serial_clock_weak <= 1'b1;
         serial_data_out <= 1'b0;
         serial_data_oe <= i2c_master_mode & ~sw_serial_data_out;
         serial_data_weak <= 1'b1;
      end
   end

   // Alternate inputs routed to peripherals
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         timer_two_count_input <= 1'b0;
         timer_two_trigger_input <= 1'b0;
         spi_slave_select_n <= 1'b1;
         uart_rxd_in <= 1'b1;
         ext_irq_zero <= 1'b1;
         ext_irq_one <= 1'b1;
         timer_zero_count_input <= 1'b0;
         timer_one_count_input <= 1'b0;
         pwm_ext_clock_in <= 1'b0;
         i2c_scl_in <= 1'b1;
         i2c_sda_in <= 1'b1;
         spi_sclk_in <= 1'b0;
         spi_mosi_in <= 1'b0;
      end
      else
      begin
         timer_two_count_input <= p1_sync[`PIO_P1_T2];
         timer_two_trigger_input <= p1_sync[`PIO_P1_TIMER_TWO_TRIGGER_INPUT];
         spi_slave_select_n <= p1_sync[`PIO_P1_SS];
         uart_rxd_in <= p3_sync[`PIO_P3_RXD];
         ext_irq_zero <= p3_sync[`PIO_P3_EXT_IRQ_ZERO];
         ext_irq_one <= p3_sync[`PIO_P3_EXT_IRQ_ONE];
         timer_zero_count_input <= p3_sync[`PIO_P3_T0];
         timer_one_count_input <= p3_sync[`PIO_P3_T1];
         pwm_ext_clock_in <= p3_sync[`PIO_P3_T0];
         i2c_scl_in <= scl_filt;
         i2c_sda_in <= sda_filt;
         spi_sclk_in <= ser_sync[0];
         spi_mosi_in <= ser_sync[1];
      end
   end

endmodule // pio_ports

`default_nettype wire

// File: logic/pio_sync_bit.v
// Two-stage synchroniser for a vector of pin levels.
// Assumes the inputs come from pins outside the sys_clk domain.
`timescale 1ns/1ps
`default_nettype none

module pio_sync_bit #(
   parameter W = 8
) (
   input wire sys_clk,
   input wire reset_n,
   input wire [W-1:0] async_in,
   output reg [W-1:0] sync_out
);

   // First stage, read only by second stage
   reg [W-1:0] meta_reg;

   // Two flip-flops in series
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_reg <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule // pio_sync_bit

`default_nettype wire

// File: sim/pio_pin_model.sv
// Pin model for the port block: resolves drive, pull and outside drivers.
// Assumes the bench enables outside drivers bit by bit.
`timescale 1ns/1ps
`default_nettype none

module pio_pin_model #(
   parameter int W = 8,
   parameter bit BOARD_PULL = 1'h0
) (
   input wire logic [W-1:0] drv_out, drv_oe, pull_en, ext_val, ext_en,
   output logic [W-1:0] pin
);
   // Low wins; an unpulled idle line shows the inverse
   always_comb
   begin
      for (int i = 0; i < W; i++)
      begin
         if (ext_en[i] && drv_oe[i])
            pin[i] = ext_val[i] & drv_out[i];
         else if (ext_en[i])
            pin[i] = ext_val[i];
         else if (drv_oe[i])
            pin[i] = drv_out[i];
         else if (pull_en[i] || BOARD_PULL)
            pin[i] = 1'h1;
         else
            pin[i] = ~ext_val[i];
      end
   end
endmodule // pio_pin_model
`default_nettype wire

// File: sim/pio_ports_assertions.sv
// Checker for the port block: read timing, pin drive and overrides.
// Assumes it is bound into the block and sees only its ports.
`include "pio_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module pio_ports_assertions (
   input wire logic sys_clk, reset_n, bus_wr_latch, bus_rd_latch, bus_rd_pin, bus_rmw,
   input wire logic [1:0] bus_sel,
   input wire logic [7:0] bus_wdata, bus_rdata, ext_data_out, ext_addr_high,
   input wire logic [7:0] port_zero_out, port_zero_oe, port_two_out, port_two_oe,
   input wire logic [7:0] port_three_out, port_one_analog_sel,
   input wire logic ext_mem_active, ext_data_phase, pwm_to_port_two, pwm_to_port_three,
   input wire logic pwm_out0, pwm_out1, spi_select_bit, i2c_master_mode, spi_sclk_out,
   input wire logic spi_sclk_oe, sw_serial_clock_out, serial_clock_out, serial_clock_oe
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   // Latch write then read back
   a_latch_read_back: assert property ((bus_wr_latch && bus_sel == 2'h2) ##1 !bus_wr_latch
      ##1 (bus_rd_latch && bus_sel == 2'h2) |=> bus_rdata == $past(bus_wdata, 3))
      else $error("latch readback");
   // Read data stands one cycle only
   a_read_idle_zero: assert property (!(bus_rd_latch || bus_rd_pin || bus_rmw)
      |=> bus_rdata == 8'h00)
      else $error("rdata idle");
   // Port one input select mirrors the latch
   a_p1_select_mirror: assert property ((bus_wr_latch && bus_sel == 2'h1)
      ##1 !(bus_wr_latch && bus_sel == 2'h1) |=> port_one_analog_sel == $past(bus_wdata, 2))
      else $error("p1 select");
   // External cycle drives port zero push-pull
   a_ext_p0_drive: assert property (ext_mem_active |=> port_zero_oe == 8'hff)
      else $error("p0 not driven");
   a_ext_p0_data: assert property (ext_mem_active && ext_data_phase
      |=> port_zero_out == $past(ext_data_out))
      else $error("p0 data");
   a_ext_p2_addr: assert property (ext_mem_active && !pwm_to_port_two
      |=> port_two_out == $past(ext_addr_high) && port_two_oe == 8'hff)
      else $error("p2 address");
   // Ones after external cycle
   a_p0_forced_ones: assert property (ext_mem_active ##1 !ext_mem_active
      ##1 (bus_rd_latch && bus_sel == 2'h0) |=> bus_rdata == 8'hff)
      else $error("p0 not forced");
   // General mode never drives port zero high
   a_p0_open_drain: assert property (!$past(ext_mem_active) && !$past(ext_mem_active, 2)
      |-> (port_zero_out & port_zero_oe) == 8'h00)
      else $error("p0 driven high");
   // PWM takes over its pins
   a_pwm_port_two: assert property (pwm_to_port_two && !ext_mem_active
      |=> port_two_out[`PIO_P2_PWM0] == $past(pwm_out0)
      && port_two_out[`PIO_P2_PWM1] == $past(pwm_out1))
      else $error("p2 pwm");
   a_pwm_port_three: assert property (pwm_to_port_three
      |=> port_three_out[4] == $past(pwm_out0) && port_three_out[3] == $past(pwm_out1))
      else $error("p3 pwm");
   // Serial clock drive by mode
   a_spi_push_pull: assert property (spi_select_bit && spi_sclk_oe
      |=> serial_clock_oe && serial_clock_out == $past(spi_sclk_out))
      else $error("spi clock drive");
   a_i2c_no_high: assert property (!spi_select_bit |=> !(serial_clock_oe && serial_clock_out))
      else $error("i2c clock high");
   a_i2c_sw_low: assert property (!spi_select_bit && i2c_master_mode && !sw_serial_clock_out
      |=> serial_clock_oe && !serial_clock_out)
      else $error("sw low");

   c_ext_cycle: cover property (ext_mem_active ##1 !ext_mem_active);
   c_pwm_three: cover property (pwm_to_port_three && pwm_out1);
   c_spi_clock: cover property (spi_select_bit && spi_sclk_oe);
endmodule // pio_ports_assertions
`default_nettype wire

// File: sim/pio_ports_test.sv
// Self-checking bench for the port block, with pin models on every port.
// Assumes one-cycle core strobes and a three-cycle pin read latency.
`include "pio_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module pio_ports_test;
   localparam int LIMIT = 6000; // Cycle ceiling
   logic sys_clk = 1'h0, reset_n = 1'h0, bus_wr_latch = 1'h0, bus_rd_latch = 1'h0;
   logic bus_rd_pin = 1'h0, bus_rmw = 1'h0, ext_mem_active = 1'h0, ext_data_phase = 1'h0;
   logic [1:0] bus_sel = 2'h0, sc_xv = 2'h3, sc_xe = 2'h0;
   logic [7:0] bus_wdata = 8'h00, ext_addr_low = 8'h00, ext_data_out = 8'h00;
   logic [7:0] ext_addr_high = 8'h00, p0_xv = 8'h00, p1_xv = 8'hff, p2_xv = 8'h00;
   logic [7:0] p2_xe = 8'h00, p3_xv = 8'h00, p3_xe = 8'h00, p0_xe = 8'h00, d;
   logic pwm_to_port_two = 1'h0, pwm_to_port_three = 1'h0, pwm_out0 = 1'h0, pwm_out1 = 1'h0;
   logic uart_txd_alt = 1'h1, uart_rxd_out_alt = 1'h1, uart_rxd_oe_alt = 1'h0;
   logic spi_miso_alt = 1'h1, spi_miso_oe_alt = 1'h0, ext_wr_strobe_n = 1'h1;
   logic ext_rd_strobe_n = 1'h1, spi_select_bit = 1'h0, i2c_master_mode = 1'h0;
   logic spi_sclk_out = 1'h0, spi_sclk_oe = 1'h0, spi_mosi_out = 1'h0, spi_mosi_oe = 1'h0;
   logic sw_serial_clock_out = 1'h1, sw_serial_data_out = 1'h1;
   wire [7:0] bus_rdata, port_zero_out, port_zero_oe, port_two_out, port_two_oe, port_two_weak;
   wire [7:0] port_three_out, port_three_oe, port_three_weak, port_one_analog_sel;
   wire [7:0] port_zero_pin_in, port_one_pin_in, port_two_pin_in, port_three_pin_in;
   wire serial_clock_out, serial_clock_oe, serial_clock_weak, serial_data_out, serial_data_oe;
   wire serial_data_weak, serial_clock_pin_in, serial_data_pin_in, timer_two_count_input;
   wire timer_two_trigger_input, spi_slave_select_n, uart_rxd_in, ext_irq_zero, ext_irq_one;
   wire timer_zero_count_input, timer_one_count_input, pwm_ext_clock_in, i2c_scl_in;
   wire i2c_sda_in, spi_sclk_in, spi_mosi_in;
   int error_cnt = 0, check_count = 0, cyc = 0;

   pio_ports dut (.*);
   // Port zero has board pull-ups; port one is input only
   pio_pin_model #(.BOARD_PULL(1'h1)) pz (.drv_out(port_zero_out), .drv_oe(port_zero_oe),
      .pull_en(8'h00), .ext_val(p0_xv), .ext_en(p0_xe), .pin(port_zero_pin_in));
   pio_pin_model po (.drv_out(8'h00), .drv_oe(8'h00),
      .pull_en(8'h00), .ext_val(p1_xv), .ext_en(8'hff), .pin(port_one_pin_in));
   pio_pin_model pt (.drv_out(port_two_out), .drv_oe(port_two_oe),
      .pull_en(port_two_weak), .ext_val(p2_xv), .ext_en(p2_xe), .pin(port_two_pin_in));
   pio_pin_model ph (.drv_out(port_three_out),
      .drv_oe(port_three_oe), .pull_en(port_three_weak), .ext_val(p3_xv), .ext_en(p3_xe),
      .pin(port_three_pin_in));
   pio_pin_model #(.W(2)) ps (.drv_out({serial_clock_out, serial_data_out}),
      .drv_oe({serial_clock_oe, serial_data_oe}), .pull_en({serial_clock_weak, serial_data_weak}),
      .ext_val(sc_xv), .ext_en(sc_xe), .pin({serial_clock_pin_in, serial_data_pin_in}));

   // Clock and cycle ceiling
   initial
   begin
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == LIMIT)
      begin
         error_cnt++;
         $display("MISMATCH %0t cycle ceiling reached", $time);
         wrap_up();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // One-cycle latch write strobe
   task automatic wr(input logic [1:0] sel, input logic [7:0] v);
      @(posedge sys_clk);
      bus_sel <= sel;
      bus_wdata <= v;
      bus_wr_latch <= 1'h1;
      @(posedge sys_clk);
      bus_wr_latch <= 1'h0;
   endtask
   // Kind 0 latch, 1 pin, 2 rmw
   task automatic rdc(input logic [1:0] sel, input int k, input logic [7:0] exp, string what);
      @(posedge sys_clk);
      bus_sel <= sel;
      bus_rd_latch <= (k == 0);
      bus_rd_pin <= (k == 1);
      bus_rmw <= (k == 2);
      @(posedge sys_clk);
      bus_rd_latch <= 1'h0;
      bus_rd_pin <= 1'h0;
      bus_rmw <= 1'h0;
      #1 chk(bus_rdata, exp, what);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'h1;
      for (int p = 0; p < 4; p++)
         rdc(2'(p), 0, 8'hff, "reset latch");
      chk(port_two_oe, 8'h00, "p2 idle");
      // Latch write, read back, pin drive
      for (int p = 0; p < 4; p++)
      begin
         d = 8'h5a ^ 8'(p);
         wr(2'(p), d);
         rdc(2'(p), 0, d, "latch read back");
      end
      settle(2);
      chk(port_zero_oe, 8'ha5, "p0 sinks");
      chk(port_zero_pin_in, 8'h5a, "p0 floats");
      chk(port_one_analog_sel, 8'h5b, "p1 select");
      chk(port_two_weak, 8'h58, "p2 pulls");
      chk(port_three_pin_in, 8'h59, "p3 levels");
      $display("test latches done");
      // Pin read, latch read, rmw
      @(posedge sys_clk);
      p2_xv <= 8'h3c;
      p2_xe <= 8'hff;
      p0_xv <= 8'h3c;
      p0_xe <= 8'hff;
      p1_xv <= 8'h96;
      wr(2'h2, 8'hff);
      settle(4);
      rdc(2'h2, 1, 8'h3c, "p2 pin");
      rdc(2'h0, 1, 8'h18, "p0 pin");
      rdc(2'h2, 2, 8'hff, "rmw reads latch");
      wr(2'h2, 8'hf0);
      rdc(2'h2, 0, 8'hf0, "rmw write back");
      p2_xe <= 8'h00;
      p0_xe <= 8'h00;
      p1_xv <= 8'h69;
      rdc(2'h1, 1, 8'h96, "pre sync");
      rdc(2'h1, 1, 8'h69, "post sync");
      chk({5'h0, spi_slave_select_n, timer_two_trigger_input, timer_two_count_input},
         8'h05, "p1 alt");
      $display("test pin reads done");
      // External memory cycle
      @(posedge sys_clk);
      ext_addr_low <= 8'h34;
      ext_addr_high <= 8'hab;
      ext_data_out <= 8'hc7;
      ext_mem_active <= 1'h1;
      wr(2'h2, 8'h12);
      wr(2'h0, 8'h00);
      settle(1);
      chk(port_zero_pin_in, 8'h34, "addr low");
      chk(port_two_pin_in, 8'hab, "addr high");
      @(posedge sys_clk);
      ext_data_phase <= 1'h1;
      settle(2);
      chk(port_zero_pin_in, 8'hc7, "data out");
      ext_mem_active <= 1'h0;
      ext_data_phase <= 1'h0;
      rdc(2'h0, 0, 8'hff, "p0 ones");
      rdc(2'h2, 0, 8'h12, "p2 kept");
      $display("test external done");
      // PWM overrides a latch of zeros
      wr(2'h2, 8'h00);
      wr(2'h3, 8'h00);
      pwm_to_port_two <= 1'h1;
      pwm_to_port_three <= 1'h1;
      for (int k = 0; k < 4; k++)
      begin
         @(posedge sys_clk);
         pwm_out0 <= k[0];
         pwm_out1 <= k[1];
         settle(2);
         chk({4'h0, port_two_pin_in[7:6], port_three_pin_in[4:3]},
            {4'h0, k[1], k[0], k[0], k[1]}, "pwm on pins");
      end
      pwm_to_port_two <= 1'h0;
      pwm_to_port_three <= 1'h0;
      $display("test pwm done");
      // Port three alternates
      wr(2'h3, 8'h3f);
      settle(2);
      chk(port_three_pin_in, 8'h3f, "p3 held low");
      wr(2'h3, 8'hff);
      ext_wr_strobe_n <= 1'h0;
      ext_rd_strobe_n <= 1'h0;
      uart_txd_alt <= 1'h0;
      uart_rxd_out_alt <= 1'h0;
      uart_rxd_oe_alt <= 1'h1;
      spi_miso_oe_alt <= 1'h1;
      spi_miso_alt <= 1'h0;
      settle(2);
      chk(port_three_pin_in, 8'h34, "alternates drive");
      ext_wr_strobe_n <= 1'h1;
      uart_txd_alt <= 1'h1;
      uart_rxd_out_alt <= 1'h1;
      spi_miso_oe_alt <= 1'h0;
      p3_xv <= 8'ha5;
      p3_xe <= 8'hff;
      settle(5);
      chk({2'h0, uart_rxd_in, ext_irq_zero, ext_irq_one, timer_zero_count_input,
         timer_one_count_input, pwm_ext_clock_in}, 8'h32, "p3 inputs");
      $display("test port three done");
      // Serial pins and filter
      spi_select_bit <= 1'h1;
      spi_sclk_oe <= 1'h1;
      spi_sclk_out <= 1'h1;
      spi_mosi_oe <= 1'h1;
      spi_mosi_out <= 1'h1;
      settle(2);
      chk({6'h0, serial_clock_pin_in, serial_data_pin_in}, 8'h03, "spi push-pull");
      spi_select_bit <= 1'h0;
      i2c_master_mode <= 1'h1;
      sw_serial_clock_out <= 1'h0;
      sw_serial_data_out <= 1'h0;
      settle(2);
      chk({5'h0, serial_data_pin_in, serial_clock_oe & serial_clock_out, serial_clock_pin_in},
         8'h00, "sw low");
      sw_serial_clock_out <= 1'h1;
      sw_serial_data_out <= 1'h1;
      settle(2);
      chk({5'h0, serial_data_pin_in, serial_clock_oe & serial_clock_out, serial_clock_pin_in},
         8'h05, "weak");
      sc_xe <= 2'h2;
      sc_xv <= 2'h1;
      settle(5);
      sc_xv <= 2'h3;
      for (int k = 0; k < 16; k++)
      begin
         settle(1);
         chk({7'h0, i2c_scl_in}, 8'h01, "pulse rejected");
      end
      sc_xv <= 2'h1;
      settle(20);
      chk({7'h0, i2c_scl_in}, 8'h00, "low accepted");
      $display("test serial done");
      wrap_up();
   end
endmodule // pio_ports_test

bind pio_ports pio_ports_assertions chk (.*);
`default_nettype wire
